//--- src/wdorc_pkg.sv
// constants and types of the watchdog overflow reset control block
//
// Contract
// - tick counter wrapping from FF to 00 in watchdog mode sets overflow_seen_flag.
// - overflow_seen_flag reads zero until an overflow occurs after it was cleared.
// - with overflow_reboot_enable zero, overflow only sets overflow_seen_flag and reinitialises counter and setup register.
// - with overflow_reboot_enable one, every overflow while no internal reset is in progress raises an internal chip reset.
// - reboot_kind_select zero gives a power-on reset, one a manual reset.
// - outcome register bits 4 to 0 always read one and ignore writes.
// - outcome register is written at one address, read at the next.
// - tick_counter is an 8-bit read/write up counter, zero while count_run is zero.
// - outcome register resets to 1F on the board init pin only.
// - mode_pick zero selects interval mode, one selects watchdog mode.
package wdorc_pkg;

  // ***************************************************************
  // clock and timing
  // ***************************************************************
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned REBOOT_HOLD_NS = 640;
  localparam int unsigned REBOOT_HOLD_CYCLES = (REBOOT_HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [7:0] REBOOT_HOLD_LAST = 8'(REBOOT_HOLD_CYCLES - 1);

  // ***************************************************************
  // register indices and byte addresses
  // ***************************************************************
  localparam logic [31:0] IDX_SETUP = 32'h00FFFF74;
  localparam logic [31:0] IDX_COUNT = 32'h00FFFF75;
  localparam logic [31:0] IDX_OUTCOME_WR = 32'h00FFFF76;
  localparam logic [31:0] IDX_OUTCOME_RD = 32'h00FFFF77;
  localparam logic [31:0] ADDR_SETUP = {IDX_SETUP[29:0], 2'h0};
  localparam logic [31:0] ADDR_COUNT = {IDX_COUNT[29:0], 2'h0};
  localparam logic [31:0] ADDR_OUTCOME_WR = {IDX_OUTCOME_WR[29:0], 2'h0};
  localparam logic [31:0] ADDR_OUTCOME_RD = {IDX_OUTCOME_RD[29:0], 2'h0};

  // ***************************************************************
  // field positions and reset values
  // ***************************************************************
  localparam int unsigned BIT_FLAG = 7;
  localparam int unsigned BIT_ENABLE = 6;
  localparam int unsigned BIT_KIND = 5;
  localparam int unsigned BIT_MODE = 6;
  localparam int unsigned BIT_RUN = 5;
  localparam logic [4:0] OUTCOME_RSVD = 5'h1F;
  localparam logic [1:0] SETUP_RSVD = 2'h3;
  localparam logic [7:0] OUTCOME_RST = 8'h1F;
  localparam logic [7:0] SETUP_RST = 8'h18;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_ZERO = 8'h00;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef struct packed {
    logic flag;
    logic enable;
    logic kind;
    logic [4:0] rsvd;
  } wdorc_outcome_type;

  typedef struct packed {
    logic ovf;
    logic mode;
    logic run;
    logic [1:0] rsvd;
    logic [2:0] clk_sel;
  } wdorc_setup_type;

  typedef enum logic [0:0] {
    WDORC_IDLE,
    WDORC_HOLD
  } wdorc_state_type;

endpackage : wdorc_pkg

//--- src/wdorc_tick_divider.sv
// prescaler giving the tick counter its count enable
`timescale 1ns/100ps
module wdorc_tick_divider (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic [2:0] clk_sel,
  // count enable pulse
  output logic tick
);

  // ***************************************************************
  // divide by 2 to the power (clk_sel + 1)
  // ***************************************************************
  logic [7:0] pre_r;
  logic [7:0] pre_nxt;
  logic tick_r;
  logic tick_nxt;
  logic [7:0] mask;

  always_comb begin
    mask = 8'hFF >> (3'h7 - clk_sel);
    pre_nxt = run ? 8'(pre_r + 8'h01) : 8'h00;
    tick_nxt = run && ((pre_r & mask) == mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule : wdorc_tick_divider

//--- src/wdorc_top.sv
// watchdog overflow reset control with tick counter and apb slave
`timescale 1ns/100ps
module wdorc_top (
  // clock and reset (presetn is the board init pin)
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // internal reset requests
  output logic power_on_reboot,
  output logic manual_reboot
);

  // ***************************************************************
  // apb decode
  // ***************************************************************
  logic hit_setup;
  logic hit_count;
  logic hit_out_wr;
  logic hit_out_rd;
  logic bad_access;
  logic access;
  logic wr_setup;
  logic wr_count;
  logic wr_outcome;

  always_comb begin
    hit_setup = (paddr == wdorc_pkg::ADDR_SETUP);
    hit_count = (paddr == wdorc_pkg::ADDR_COUNT);
    hit_out_wr = (paddr == wdorc_pkg::ADDR_OUTCOME_WR);
    hit_out_rd = (paddr == wdorc_pkg::ADDR_OUTCOME_RD);
    // outcome register answers writes only at one address, reads only at the other
    bad_access = !(hit_setup || hit_count || (hit_out_wr && pwrite) || (hit_out_rd && !pwrite));
    access = psel && penable;
    wr_setup = access && pwrite && hit_setup;
    wr_count = access && pwrite && hit_count;
    wr_outcome = access && pwrite && hit_out_wr;
  end

  assign pready = 1'b1;
  assign pslverr = access && bad_access;

  // ***************************************************************
  // tick source
  // ***************************************************************
  wdorc_pkg::wdorc_setup_type setup_r;
  wdorc_pkg::wdorc_setup_type setup_nxt;
  logic tick;

  wdorc_tick_divider u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .run(setup_r.run),
    .clk_sel(setup_r.clk_sel),
    .tick(tick)
  );

  // ***************************************************************
  // counter, setup and outcome registers
  // ***************************************************************
  wdorc_pkg::wdorc_outcome_type outcome_r;
  wdorc_pkg::wdorc_outcome_type outcome_nxt;
  logic [7:0] counter_r;
  logic [7:0] counter_nxt;
  logic ovf;
  logic ovf_wd;
  logic ovf_int;

  always_comb begin
    ovf = tick && setup_r.run && (counter_r == wdorc_pkg::COUNT_MAX);
    ovf_wd = ovf && setup_r.mode;
    ovf_int = ovf && !setup_r.mode;
    counter_nxt = counter_r;
    setup_nxt = setup_r;
    outcome_nxt = outcome_r;
    if (tick && setup_r.run) begin
      counter_nxt = 8'(counter_r + 8'h01);
    end
    if (wr_count) begin
      counter_nxt = pwdata[7:0];
    end
    if (wr_setup) begin
      setup_nxt.mode = pwdata[wdorc_pkg::BIT_MODE];
      setup_nxt.run = pwdata[wdorc_pkg::BIT_RUN];
      setup_nxt.clk_sel = pwdata[2:0];
      if (!pwdata[wdorc_pkg::BIT_FLAG]) begin
        setup_nxt.ovf = 1'b0;
      end
    end
    if (wr_outcome) begin
      outcome_nxt.enable = pwdata[wdorc_pkg::BIT_ENABLE];
      outcome_nxt.kind = pwdata[wdorc_pkg::BIT_KIND];
      // writing zero clears the flag, writing one leaves it
      if (!pwdata[wdorc_pkg::BIT_FLAG]) begin
        outcome_nxt.flag = 1'b0;
      end
    end
    // interval mode flags the wrap in the setup register
    if (ovf_int) begin
      setup_nxt.ovf = 1'b1;
    end
    // watchdog wrap: set wins over a same-cycle clear, then counter and setup return to reset values, which stops the count
    if (ovf_wd) begin
      outcome_nxt.flag = 1'b1;
      counter_nxt = wdorc_pkg::COUNT_ZERO;
      setup_nxt = wdorc_pkg::SETUP_RST;
    end
    if (!setup_nxt.run) begin
      counter_nxt = wdorc_pkg::COUNT_ZERO;
    end
    setup_nxt.rsvd = wdorc_pkg::SETUP_RSVD;
    outcome_nxt.rsvd = wdorc_pkg::OUTCOME_RSVD;
  end

  // outcome register is reset by the board init pin and by nothing else
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outcome_r <= wdorc_pkg::OUTCOME_RST;
      setup_r <= wdorc_pkg::SETUP_RST;
      counter_r <= wdorc_pkg::COUNT_ZERO;
    end else begin
      outcome_r <= outcome_nxt;
      setup_r <= setup_nxt;
      counter_r <= counter_nxt;
    end
  end

  // ***************************************************************
  // internal reset sequencer
  // ***************************************************************
  wdorc_pkg::wdorc_state_type state_r;
  wdorc_pkg::wdorc_state_type state_nxt;
  logic [7:0] hold_r;
  logic [7:0] hold_nxt;
  logic kind_r;
  logic kind_nxt;
  logic por_r;
  logic por_nxt;
  logic man_r;
  logic man_nxt;

  always_comb begin
    state_nxt = state_r;
    hold_nxt = hold_r;
    kind_nxt = kind_r;
    case (state_r)
      wdorc_pkg::WDORC_IDLE: begin
        // kind is sampled only when a reset is really raised
        if (ovf_wd && outcome_r.enable) begin
          state_nxt = wdorc_pkg::WDORC_HOLD;
          hold_nxt = wdorc_pkg::REBOOT_HOLD_LAST;
          kind_nxt = outcome_r.kind;
        end
      end
      wdorc_pkg::WDORC_HOLD: begin
        if (hold_r == 8'h00) begin
          state_nxt = wdorc_pkg::WDORC_IDLE;
        end else begin
          hold_nxt = 8'(hold_r - 8'h01);
        end
      end
      default: begin
        state_nxt = wdorc_pkg::WDORC_IDLE;
      end
    endcase
    por_nxt = (state_nxt == wdorc_pkg::WDORC_HOLD) && !kind_nxt;
    man_nxt = (state_nxt == wdorc_pkg::WDORC_HOLD) && kind_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= wdorc_pkg::WDORC_IDLE;
      hold_r <= 8'h00;
      kind_r <= 1'b0;
      por_r <= 1'b0;
      man_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      kind_r <= kind_nxt;
      por_r <= por_nxt;
      man_r <= man_nxt;
    end
  end

  assign power_on_reboot = por_r;
  assign manual_reboot = man_r;

  // ***************************************************************
  // read data, captured in the setup phase
  // ***************************************************************
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  always_comb begin
    prdata_nxt = prdata_r;
    if (psel && !penable && !pwrite) begin
      prdata_nxt = 32'h00000000;
      if (hit_setup) begin
        prdata_nxt[7:0] = setup_r;
      end
      if (hit_count) begin
        prdata_nxt[7:0] = counter_r;
      end
      if (hit_out_rd) begin
        prdata_nxt[7:0] = outcome_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_flag_sets: assert property (
    ovf_wd |=> outcome_r.flag
  ) else $error("overflow did not set the flag");

  chk_flag_quiet: assert property (
    (!outcome_r.flag && !ovf_wd) |=> !outcome_r.flag
  ) else $error("flag rose without an overflow");

  chk_no_reboot: assert property (
    (ovf_wd && !outcome_r.enable && state_r == wdorc_pkg::WDORC_IDLE)
      |=> (!power_on_reboot && !manual_reboot && counter_r == 8'h00 && !setup_r.run)
  ) else $error("disabled overflow did more than reinitialise");

  chk_reboot_fires: assert property (
    (ovf_wd && outcome_r.enable && state_r == wdorc_pkg::WDORC_IDLE)
      |=> (power_on_reboot || manual_reboot) [*8]
  ) else $error("internal reset not raised on overflow");

  chk_reboot_kind: assert property (
    (ovf_wd && outcome_r.enable && state_r == wdorc_pkg::WDORC_IDLE)
      |=> (power_on_reboot == !$past(outcome_r.kind)) && (manual_reboot == $past(outcome_r.kind))
  ) else $error("internal reset of the wrong kind");

  chk_rsvd_ones: assert property (
    (psel && !penable && !pwrite && hit_out_rd) |=> (prdata[7:0] == $past(outcome_r)) && (prdata[4:0] == 5'h1F)
  ) else $error("reserved outcome bits did not read one");

  chk_split_decode: assert property (
    (access && pwrite && hit_out_rd && !ovf_wd) |-> pslverr ##1 $stable(outcome_r)
  ) else $error("write at the read address was not refused");

  chk_count_held: assert property (
    (!setup_r.run && !wr_setup) |=> (counter_r == 8'h00)
  ) else $error("counter moved while stopped");

  chk_outcome_kept: assert property (
    (state_r == wdorc_pkg::WDORC_HOLD && !wr_outcome) |=> $stable(outcome_r.enable) && $stable(outcome_r.kind)
  ) else $error("outcome register changed during internal reset");

  chk_interval_mode: assert property (
    ovf_int |=> setup_r.ovf && !$rose(outcome_r.flag) && !$rose(power_on_reboot) && !$rose(manual_reboot)
  ) else $error("interval overflow acted as watchdog");

  chk_kind_ignored: assert property (
    (state_r == wdorc_pkg::WDORC_IDLE && !(ovf_wd && outcome_r.enable)) |=> (!power_on_reboot && !manual_reboot)
  ) else $error("reset raised while disabled");

  chk_count_steps: assert property (
    (tick && setup_r.run && !ovf && !wr_count && !wr_setup) |=> (counter_r == 8'($past(counter_r) + 8'h01))
  ) else $error("counter did not count up");

  chk_interval_wrap: assert property (
    (ovf_int && !wr_count && !wr_setup) |=> (counter_r == 8'h00)
  ) else $error("interval overflow did not wrap the counter");

  chk_setup_reinit: assert property (
    ovf_wd |=> (setup_r == wdorc_pkg::SETUP_RST) && (counter_r == wdorc_pkg::COUNT_ZERO)
  ) else $error("watchdog overflow did not reinitialise counter and setup");

  chk_read_refused: assert property (
    (access && !pwrite && hit_out_wr) |-> pslverr
  ) else $error("read at the write address was not refused");

  chk_flag_clear: assert property (
    (wr_outcome && !pwdata[wdorc_pkg::BIT_FLAG] && !ovf_wd) |=> !outcome_r.flag
  ) else $error("flag not cleared by a write of zero");

  chk_rsvd_kept: assert property (
    outcome_r.rsvd == wdorc_pkg::OUTCOME_RSVD
  ) else $error("reserved outcome bits left their fixed value");

  chk_reboot_exclusive: assert property (
    !(power_on_reboot && manual_reboot)
  ) else $error("both internal reset kinds raised together");

endmodule : wdorc_top

//--- testbench/testbench.sv
// self-checking bench for the watchdog overflow reset control block
`timescale 1ns/100ps
module testbench;
  // ****************************************
  // signals
  // ****************************************
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic power_on_reboot;
  logic manual_reboot;
  int fail_count;
  int checks;
  int por_cycles;
  int man_cycles;

  wdorc_top wdorc_top_i (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .power_on_reboot(power_on_reboot),
    .manual_reboot(manual_reboot)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // counts the cycles each reboot request is high
  always @(posedge pclk) begin
    if (power_on_reboot === 1'b1) por_cycles++;
    if (manual_reboot === 1'b1) man_cycles++;
  end

  // ****************************************
  // helpers
  // ****************************************
  task end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task apb(input logic wr, input logic [31:0] addr, input logic [31:0] data, output logic [31:0] rd,
           output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [31:0] addr, input logic [7:0] data);
    logic [31:0] rd;
    logic err;
    apb(1'b1, addr, {24'h000000, data}, rd, err);
    check("write error", 32'h00000000, {31'h00000000, err});
  endtask : wr

  task rd_chk(input string what, input logic [31:0] addr, input logic [7:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, addr, 32'h00000000, rd, err);
    check(what, {24'h000000, exp}, rd);
    check("read error", 32'h00000000, {31'h00000000, err});
  endtask : rd_chk

  // polls a register until the given bit is set
  task wait_bit(input logic [31:0] addr, input int bitpos);
    logic [31:0] rd;
    logic err;
    int n;
    n = 0;
    do begin
      apb(1'b0, addr, 32'h00000000, rd, err);
      n++;
    end while (rd[bitpos] !== 1'b1 && n < 200);
    if (n >= 200) begin
      fail_count++;
      end_of_test();
    end
  endtask : wait_bit

  // ****************************************
  // scenarios
  // ****************************************
  task reset_values;
    rd_chk("outcome reset", wdorc_pkg::ADDR_OUTCOME_RD, 8'h1F);
    rd_chk("setup reset", wdorc_pkg::ADDR_SETUP, 8'h18);
    rd_chk("counter reset", wdorc_pkg::ADDR_COUNT, 8'h00);
  endtask : reset_values

  task outcome_access;
    logic [31:0] rd;
    logic err;
    wr(wdorc_pkg::ADDR_OUTCOME_WR, 8'hFF);
    rd_chk("outcome fixed bits", wdorc_pkg::ADDR_OUTCOME_RD, 8'h7F);
    apb(1'b1, wdorc_pkg::ADDR_OUTCOME_RD, 32'h00000000, rd, err);
    check("write to read address refused", 32'h00000001, {31'h00000000, err});
    rd_chk("outcome unchanged", wdorc_pkg::ADDR_OUTCOME_RD, 8'h7F);
    apb(1'b0, wdorc_pkg::ADDR_OUTCOME_WR, 32'h00000000, rd, err);
    check("read of write address refused", 32'h00000001, {31'h00000000, err});
    apb(1'b0, 32'h00000100, 32'h00000000, rd, err);
    check("unmapped read refused", 32'h00000001, {31'h00000000, err});
    wr(wdorc_pkg::ADDR_OUTCOME_WR, 8'h00);
    rd_chk("outcome cleared", wdorc_pkg::ADDR_OUTCOME_RD, 8'h1F);
    wr(wdorc_pkg::ADDR_COUNT, 8'h55);
    rd_chk("counter held while stopped", wdorc_pkg::ADDR_COUNT, 8'h00);
  endtask : outcome_access

  task watchdog_overflow(input logic [7:0] ctl, input logic [7:0] exp_out, input int exp_por, input int exp_man);
    wr(wdorc_pkg::ADDR_OUTCOME_WR, ctl);
    rd_chk("flag before overflow", wdorc_pkg::ADDR_OUTCOME_RD, exp_out & 8'h7F);
    por_cycles = 0;
    man_cycles = 0;
    wr(wdorc_pkg::ADDR_SETUP, 8'h60);
    wr(wdorc_pkg::ADDR_COUNT, 8'hFE);
    wait_bit(wdorc_pkg::ADDR_OUTCOME_RD, 7);
    repeat (24) @(posedge pclk);
    rd_chk("outcome after overflow", wdorc_pkg::ADDR_OUTCOME_RD, exp_out);
    rd_chk("setup reinitialised", wdorc_pkg::ADDR_SETUP, 8'h18);
    rd_chk("counter reinitialised", wdorc_pkg::ADDR_COUNT, 8'h00);
    check("power-on reboot cycles", exp_por, por_cycles);
    check("manual reboot cycles", exp_man, man_cycles);
    wr(wdorc_pkg::ADDR_OUTCOME_WR, ctl);
    rd_chk("flag cleared", wdorc_pkg::ADDR_OUTCOME_RD, exp_out & 8'h7F);
  endtask : watchdog_overflow

  task interval_overflow;
    wr(wdorc_pkg::ADDR_OUTCOME_WR, 8'h40);
    por_cycles = 0;
    man_cycles = 0;
    wr(wdorc_pkg::ADDR_SETUP, 8'h21);
    wr(wdorc_pkg::ADDR_COUNT, 8'hFE);
    wait_bit(wdorc_pkg::ADDR_SETUP, 7);
    rd_chk("interval mode setup", wdorc_pkg::ADDR_SETUP, 8'hB9);
    rd_chk("no watchdog flag", wdorc_pkg::ADDR_OUTCOME_RD, 8'h5F);
    check("no reboot in interval mode", 0, por_cycles + man_cycles);
    wr(wdorc_pkg::ADDR_SETUP, 8'h00);
    rd_chk("counter zero when stopped", wdorc_pkg::ADDR_COUNT, 8'h00);
  endtask : interval_overflow

  task pin_reset;
    wr(wdorc_pkg::ADDR_OUTCOME_WR, 8'h60);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("outcome after pin reset", wdorc_pkg::ADDR_OUTCOME_RD, 8'h1F);
  endtask : pin_reset

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    fail_count = 0;
    checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    reset_values();
    outcome_access();
    watchdog_overflow(8'h20, 8'hBF, 0, 0);
    watchdog_overflow(8'h40, 8'hDF, wdorc_pkg::REBOOT_HOLD_CYCLES, 0);
    watchdog_overflow(8'h60, 8'hFF, 0, wdorc_pkg::REBOOT_HOLD_CYCLES);
    interval_overflow();
    pin_reset();
    end_of_test();
  end

  initial begin
    #1000000;
    fail_count++;
    end_of_test();
  end
endmodule : testbench
